/* File: lcp_pkg.sv */
// package: register map, device map, timing and types for the lamp config port master
package lcp_pkg;
  // ----------------------------------------
  // own registers on the AHB-Lite slave
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_MEM = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_BIT = 1;
  localparam int CTRL_SEL_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RDATA_LSB = 8;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // ----------------------------------------
  // device side map
  // ----------------------------------------
  localparam logic [5:0] ADDR_PREFIX = 6'h28;
  localparam logic [7:0] CTRL_TWO_ADDR = 8'hF5;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h08;
  localparam logic [7:0] USER_MEM_BASE = 8'hF8;
  localparam int C2_WRITE_PERMIT_BIT = 0;
  localparam int C2_OSC_RANGE_LSB = 1;
  localparam int C2_SAMPLE_RATE_LSB = 3;
  localparam int C2_CHAN_DISABLE_LSB = 5;
  localparam int C2_RESERVED_BIT = 7;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_QTR_NS = 2500;
  localparam int QTR_CYCLES = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_BIT = 2'b10,
    ST_STOP = 2'b11
  } lcp_state_t;
  typedef struct packed {
    logic op_read;
    logic dev_sel;
    logic [7:0] mem;
    logic [7:0] wdata;
  } lcp_cmd_t;
endpackage : lcp_pkg

/* File: lcp_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lcp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      meta <= '1;
      o_sync <= '1;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : lcp_sync

/* File: lcp_div.sv */
// divider giving a one-cycle enable pulse every DIV cycles while enabled
`timescale 1ns/1ps
module lcp_div #(
  parameter int DIV = 4
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_en,
  output logic o_tick
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_tick;
  if (DIV < 2) begin : g_bad
    $error("lcp_div: DIV must be at least 2");
  end
  always_comb begin
    next_cnt = '0;
    next_tick = 1'b0;
    if (i_en) begin
      if (cnt == CW'(DIV - 1)) begin
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule : lcp_div

/* File: lcp_master.sv */
// two-wire master for the lamp controller config port, driven from an AHB-Lite slave
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
//
// Contract
// - host keeps control_two bit7 at zero
// - host makes every clock, start, stop
// - start: data falls while clock high
// - stop: data rises while clock high
// - repeated start begins new transfer
// - host changes data only while clock low
// - host releases data before reading bits
// - ninth bit is acknowledge from receiver
// - eight bits msb first then acknowledge
// - host not-acknowledges last read byte
// - second write byte is memory address
// - write: address, memory, data, stop
// - read: address, memory, restart, address, byte
module lcp_master #(
  parameter int QTR = lcp_pkg::QTR_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  output logic o_scl_out,
  output logic o_scl_oe_n,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n
);
  if (QTR < 2) begin : g_bad
    $error("lcp_master: QTR must be at least 2");
  end

  // ----------------------------------------
  // pins and quarter-period tick
  // ----------------------------------------
  logic sda_s;
  logic tick;
  logic busy;
  lcp_sync #(.WIDTH(1)) u_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async(i_sda),
    .o_sync(sda_s)
  );
  lcp_div #(.DIV(QTR)) u_div (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_en(busy),
    .o_tick(tick)
  );
  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  logic a_valid;
  logic a_write;
  logic [3:0] a_addr;
  lcp_pkg::lcp_cmd_t cmd;
  logic nack;
  logic [7:0] rdata;
  logic next_a_valid;
  logic next_a_write;
  logic [3:0] next_a_addr;
  logic [31:0] next_hrdata;
  lcp_pkg::lcp_cmd_t next_cmd;
  logic start_req;
  logic addr_phase;

  assign addr_phase = i_hsel && i_htrans[1] && i_hready;

  always_comb begin
    next_a_valid = addr_phase;
    next_a_write = i_hwrite;
    next_a_addr = {i_haddr[3:2], 2'b00};
    next_hrdata = 32'h0000_0000;
    next_cmd = cmd;
    start_req = 1'b0;
    if (addr_phase && !i_hwrite) begin
      case ({i_haddr[3:2], 2'b00})
        lcp_pkg::REG_CTRL: begin
          next_hrdata[lcp_pkg::CTRL_OP_BIT] = cmd.op_read;
          next_hrdata[lcp_pkg::CTRL_SEL_BIT] = cmd.dev_sel;
        end
        lcp_pkg::REG_MEM: next_hrdata[7:0] = cmd.mem;
        lcp_pkg::REG_WDATA: next_hrdata[7:0] = cmd.wdata;
        lcp_pkg::REG_STATUS: begin
          next_hrdata[lcp_pkg::STAT_BUSY_BIT] = busy;
          next_hrdata[lcp_pkg::STAT_NACK_BIT] = nack;
          next_hrdata[lcp_pkg::STAT_RDATA_LSB +: 8] = rdata;
        end
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
    if (a_valid && a_write && !busy) begin
      case (a_addr)
        lcp_pkg::REG_CTRL: begin
          next_cmd.op_read = i_hwdata[lcp_pkg::CTRL_OP_BIT];
          next_cmd.dev_sel = i_hwdata[lcp_pkg::CTRL_SEL_BIT];
          start_req = i_hwdata[lcp_pkg::CTRL_GO_BIT];
        end
        lcp_pkg::REG_MEM: next_cmd.mem = i_hwdata[7:0];
        lcp_pkg::REG_WDATA: next_cmd.wdata = i_hwdata[7:0];
        default: next_cmd = cmd;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      a_valid <= 1'b0;
      a_write <= 1'b0;
      a_addr <= 4'h0;
      o_hrdata <= 32'h0000_0000;
      cmd <= '{1'b0, 1'b0, lcp_pkg::CMD_RESET, lcp_pkg::CMD_RESET};
    end else begin
      a_valid <= next_a_valid;
      a_write <= next_a_write;
      a_addr <= next_a_addr;
      o_hrdata <= next_hrdata;
      cmd <= next_cmd;
    end
  end

  // ----------------------------------------
  // byte loader
  // ----------------------------------------
  function automatic logic [8:0] load_byte(input logic [1:0] idx, input lcp_pkg::lcp_cmd_t c);
    logic [7:0] wd;
    wd = c.wdata;
    if (c.mem == lcp_pkg::CTRL_TWO_ADDR) begin
      wd[lcp_pkg::C2_RESERVED_BIT] = 1'b0;
    end
    case (idx)
      2'd0: load_byte = {lcp_pkg::ADDR_PREFIX, c.dev_sel, 1'b0, 1'b1};
      2'd1: load_byte = {c.mem, 1'b1};
      2'd2: load_byte = c.op_read ? {lcp_pkg::ADDR_PREFIX, c.dev_sel, 1'b1, 1'b1}
                                  : {wd, 1'b1};
      default: load_byte = 9'h1FF;
    endcase
  endfunction : load_byte

  // ----------------------------------------
  // bus engine
  // ----------------------------------------
  lcp_pkg::lcp_state_t st;
  lcp_pkg::lcp_state_t next_st;
  logic [1:0] q;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [8:0] shift;
  logic [8:0] rx;
  logic next_scl_oe_n;
  logic next_sda_oe_n;
  logic [1:0] next_q;
  logic [3:0] next_bit_cnt;
  logic [1:0] next_byte_idx;
  logic [8:0] next_shift;
  logic [8:0] next_rx;
  logic next_busy;
  logic next_nack;
  logic [7:0] next_rdata;

  always_comb begin
    next_st = st;
    next_scl_oe_n = o_scl_oe_n;
    next_sda_oe_n = o_sda_oe_n;
    next_q = q;
    next_bit_cnt = bit_cnt;
    next_byte_idx = byte_idx;
    next_shift = shift;
    next_rx = rx;
    next_busy = busy;
    next_nack = nack;
    next_rdata = rdata;
    if (st == lcp_pkg::ST_IDLE) begin
      next_scl_oe_n = 1'b1;
      next_sda_oe_n = 1'b1;
      if (start_req) begin
        next_st = lcp_pkg::ST_START;
        next_q = 2'd0;
        next_byte_idx = 2'd0;
        next_busy = 1'b1;
        next_nack = 1'b0;
      end
    end else if (tick) begin
      next_q = q + 2'd1;
      case (st)
        lcp_pkg::ST_START: begin
          case (q)
            2'd0: next_sda_oe_n = 1'b1;
            2'd1: next_scl_oe_n = 1'b1;
            2'd2: next_sda_oe_n = 1'b0;
            default: begin
              next_scl_oe_n = 1'b0;
              next_st = lcp_pkg::ST_BIT;
              next_shift = load_byte(byte_idx, cmd);
              next_bit_cnt = 4'd0;
            end
          endcase
        end
        lcp_pkg::ST_BIT: begin
          case (q)
            2'd0: next_sda_oe_n = shift[8];
            2'd1: next_scl_oe_n = 1'b1;
            2'd2: next_rx = {rx[7:0], sda_s};
            default: begin
              next_scl_oe_n = 1'b0;
              if (bit_cnt != 4'd8) begin
                next_bit_cnt = bit_cnt + 4'd1;
                next_shift = {shift[7:0], 1'b1};
              end else if (cmd.op_read && byte_idx == 2'd3) begin
                next_rdata = rx[8:1];
                next_st = lcp_pkg::ST_STOP;
              end else if (rx[0]) begin
                next_nack = 1'b1;
                next_st = lcp_pkg::ST_STOP;
              end else if (!cmd.op_read && byte_idx == 2'd2) begin
                next_st = lcp_pkg::ST_STOP;
              end else if (cmd.op_read && byte_idx == 2'd1) begin
                next_byte_idx = 2'd2;
                next_st = lcp_pkg::ST_START;
              end else begin
                next_byte_idx = byte_idx + 2'd1;
                next_shift = load_byte(byte_idx + 2'd1, cmd);
                next_bit_cnt = 4'd0;
              end
            end
          endcase
        end
        lcp_pkg::ST_STOP: begin
          case (q)
            2'd0: next_sda_oe_n = 1'b0;
            2'd1: next_scl_oe_n = 1'b1;
            2'd2: next_sda_oe_n = 1'b1;
            default: begin
              next_st = lcp_pkg::ST_IDLE;
              next_busy = 1'b0;
            end
          endcase
        end
        default: next_st = lcp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      st <= lcp_pkg::ST_IDLE;
      o_scl_oe_n <= 1'b1;
      o_sda_oe_n <= 1'b1;
      q <= 2'd0;
      bit_cnt <= 4'd0;
      byte_idx <= 2'd0;
      shift <= 9'h1FF;
      rx <= 9'h000;
      busy <= 1'b0;
      nack <= 1'b0;
      rdata <= 8'h00;
    end else begin
      st <= next_st;
      o_scl_oe_n <= next_scl_oe_n;
      o_sda_oe_n <= next_sda_oe_n;
      q <= next_q;
      bit_cnt <= next_bit_cnt;
      byte_idx <= next_byte_idx;
      shift <= next_shift;
      rx <= next_rx;
      busy <= next_busy;
      nack <= next_nack;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  AST_IDLE_RELEASED: assert property ((st == lcp_pkg::ST_IDLE && !start_req) |=>
    (o_scl_oe_n && o_sda_oe_n)) else $error("lines not released while idle");
  AST_SDA_CHG_LOW: assert property ((st == lcp_pkg::ST_BIT && $past(st) == lcp_pkg::ST_BIT
    && $changed(o_sda_oe_n)) |-> !o_scl_oe_n) else $error("data moved while clock high");
  AST_START_COND: assert property (($past(st) == lcp_pkg::ST_START && $fell(o_sda_oe_n))
    |-> o_scl_oe_n) else $error("start without clock high");
  AST_STOP_COND: assert property (($past(st) == lcp_pkg::ST_STOP && $rose(o_sda_oe_n))
    |-> (o_scl_oe_n && $past(o_scl_oe_n))) else $error("stop without clock high");
  AST_ADDR_BYTE: assert property (($past(st) == lcp_pkg::ST_START && st == lcp_pkg::ST_BIT)
    |-> shift[8:1] == {lcp_pkg::ADDR_PREFIX, cmd.dev_sel, byte_idx == 2'd2})
    else $error("bad address byte");
  AST_READ_RELEASE: assert property ((st == lcp_pkg::ST_BIT && cmd.op_read
    && byte_idx == 2'd3 && q == 2'd1) |-> o_sda_oe_n) else $error("host drove read byte");
  AST_C2_BIT7: assert property (($changed(byte_idx) && byte_idx == 2'd2 && !cmd.op_read
    && cmd.mem == lcp_pkg::CTRL_TWO_ADDR) |-> !shift[8]) else $error("reserved bit set");
  AST_MSB_FIRST: assert property ((st == lcp_pkg::ST_BIT && tick && q == 2'd3
    && bit_cnt != 4'd8) |=> shift[8] == $past(shift[7])) else $error("bit order broken");
  AST_NACK_STOP: assert property (($past(st) == lcp_pkg::ST_BIT && st == lcp_pkg::ST_STOP)
    |-> (nack || byte_idx == 2'd3 || (!cmd.op_read && byte_idx == 2'd2)))
    else $error("stop without cause");
  AST_GO_BUSY: assert property (start_req |=> (busy && st == lcp_pkg::ST_START ##1 busy))
    else $error("go not taken");

  COV_WRITE: cover property ($fell(busy) && !cmd.op_read && !nack);
  COV_READ: cover property ($fell(busy) && cmd.op_read && !nack);
  COV_NACK: cover property ($rose(nack));
  COV_RESTART: cover property ($past(st) == lcp_pkg::ST_BIT && st == lcp_pkg::ST_START);
endmodule : lcp_master

/* File: lcp_dev_model.sv */
// behavioural model of the lamp controller serial config port
`timescale 1ns/1ps
module lcp_dev_model #(
  parameter logic SEL = 1'b0,
  parameter int BUSY_NS = 3000
) (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_pull,
  output logic o_fault,
  output logic [7:0] o_starts
);
  logic [7:0] mem [0:255];
  logic [7:0] ptr;
  logic [7:0] sh;
  logic act;
  logic rd;
  logic nv;
  logic busy;
  int cnt;
  int phase;
  // ----------------------------------------
  // contents and conditions
  // ----------------------------------------
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem[lcp_pkg::CTRL_TWO_ADDR] = lcp_pkg::CTRL_TWO_RESET;
    {o_sda_pull, o_fault, act, rd, nv, busy} = 6'h00;
    {cnt, phase} = '0;
    o_starts = 8'h00;
    ptr = 8'h00;
  end
  always @(negedge i_sda) begin
    if (i_scl === 1'b1) begin
      act = 1'b1;
      rd = 1'b0;
      cnt = 0;
      phase = 0;
      o_starts = o_starts + 8'h01;
    end
  end
  always @(posedge i_sda) begin
    if (i_scl === 1'b1) begin
      act = 1'b0;
      if (nv) begin
        busy = 1'b1;
        nv = 1'b0;
        busy <= #(BUSY_NS) 1'b0;
      end
    end
  end
  // ----------------------------------------
  // bit engine
  // ----------------------------------------
  task automatic take_byte();
    if (phase == 0) begin
      if (sh[7:1] !== {lcp_pkg::ADDR_PREFIX, SEL} || busy) begin
        act = 1'b0;
        o_sda_pull = 1'b0;
      end
      rd = sh[0];
    end else if (phase == 1) begin
      ptr = sh;
    end else begin
      if (ptr == lcp_pkg::CTRL_TWO_ADDR && sh[7]) o_fault = 1'b1;
      if (ptr < lcp_pkg::USER_MEM_BASE || mem[lcp_pkg::CTRL_TWO_ADDR][0]) begin
        mem[ptr] = sh;
        nv = 1'b1;
      end
      ptr = ptr + 8'h01;
    end
    phase = phase + 1;
  endtask : take_byte
  always @(posedge i_scl) begin
    if (act && cnt < 8 && !rd) sh = {sh[6:0], i_sda};
    else if (act && cnt == 8 && rd && i_sda) act = 1'b0;
    if (act) cnt = cnt + 1;
  end
  always @(negedge i_scl) begin
    if (act && cnt == 8 && !rd) begin
      o_sda_pull = 1'b1;
      take_byte();
    end else if (act && cnt == 9) begin
      cnt = 0;
      o_sda_pull = 1'b0;
      if (rd) sh = mem[ptr];
      if (rd) ptr = ptr + 8'h01;
    end else if (act && cnt == 8) begin
      o_sda_pull = 1'b0;
    end
    if (act && rd && cnt < 8) o_sda_pull = !sh[7 - cnt];
  end
endmodule : lcp_dev_model

/* File: lcp_master_test.sv */
// self-checking bench for the lamp config port master against a device model
`timescale 1ns/1ps
module lcp_master_test;
  logic mclk;
  logic reset;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  wire logic hready, hresp, scl_out, scl_oe_n, sda_out, sda_oe_n, dev_pull, fault;
  wire logic [31:0] hrdata;
  wire logic [7:0] starts;
  wire logic scl = (scl_oe_n === 1'b0) ? scl_out : 1'b1;
  wire logic sda = ((sda_oe_n === 1'b0) ? sda_out : 1'b1) & !dev_pull;
  int failures;
  int cmp_count;
  lcp_master #(.QTR(4)) dut_u (.i_mclk(mclk), .i_reset(reset), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
    .o_hrdata(hrdata), .o_scl_out(scl_out), .o_scl_oe_n(scl_oe_n), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n));
  lcp_dev_model #(.SEL(1'b0)) dev_u (.i_scl(scl), .i_sda(sda), .o_sda_pull(dev_pull),
    .o_fault(fault), .o_starts(starts));
  always #2.5 mclk = ~mclk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic edge_wait(output logic [31:0] r);
    int n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    while (rdy !== 1'b1) begin
      @(negedge mclk);
      rdy = hready;
      r = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
      @(posedge mclk);
      n++;
      if (n > 50) begin
        chk("hready wait", 1, 0);
        end_sim();
      end
    end
  endtask : edge_wait
  task automatic ahb(input logic [3:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r);
    haddr <= {28'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    edge_wait(r);
    htrans <= 2'h0;
    hwdata <= d;
    edge_wait(r);
  endtask : ahb
  task automatic xfer(input logic op, input logic s, input logic [7:0] m, input logic [7:0] d,
      output logic [31:0] st);
    logic [31:0] r;
    int n;
    ahb(lcp_pkg::REG_MEM, 1'b1, {24'h0, m}, r);
    ahb(lcp_pkg::REG_WDATA, 1'b1, {24'h0, d}, r);
    ahb(lcp_pkg::REG_CTRL, 1'b1, {29'h0, s, op, 1'b1}, r);
    n = 0;
    st = 32'h1;
    while (st[lcp_pkg::STAT_BUSY_BIT] !== 1'b0) begin
      ahb(lcp_pkg::REG_STATUS, 1'b0, 32'h0, st);
      n++;
      if (n > 2000) begin
        chk("busy wait", 0, 1);
        end_sim();
      end
    end
    chk("scl idle", 1, {31'h0, scl});
    chk("sda idle", 1, {31'h0, sda});
  endtask : xfer
  task automatic poll(input logic op, input logic [7:0] m, input logic [7:0] d,
      output logic [31:0] st);
    int n;
    n = 0;
    st = 32'h2;
    while (st[lcp_pkg::STAT_NACK_BIT] !== 1'b0) begin
      xfer(op, 1'b0, m, d, st);
      n++;
      if (n > 20) begin
        chk("ack poll", 0, 1);
        end_sim();
      end
    end
  endtask : poll
  task automatic get(input logic [7:0] m, input logic [7:0] exp);
    logic [31:0] st;
    poll(1'b1, m, 8'h00, st);
    chk("read byte", {24'h0, exp}, {24'h0, st[15:8]});
  endtask : get
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    logic [7:0] s0;
    ahb(lcp_pkg::REG_STATUS, 1'b1, 32'hFFFF_FFFF, r);
    ahb(lcp_pkg::REG_STATUS, 1'b0, 32'h0, r);
    chk("status after reset", 32'h0, r);
    s0 = starts;
    xfer(1'b1, 1'b0, lcp_pkg::CTRL_TWO_ADDR, 8'h00, r);
    chk("control_two reset", {16'h0, lcp_pkg::CTRL_TWO_RESET, 8'h00}, r);
    chk("starts per read", 8'h02, starts - s0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fields();
    logic [31:0] st;
    logic [1:0] c;
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      v = {1'b0, c, c, c, 1'b1};
      poll(1'b0, lcp_pkg::CTRL_TWO_ADDR, v, st);
      get(lcp_pkg::CTRL_TWO_ADDR, v);
    end
    $display("test fields done");
  endtask : t_fields
  task automatic t_busy();
    logic [31:0] st;
    xfer(1'b0, 1'b0, 8'hF8, 8'h3C, st);
    chk("first write ack", 0, {31'h0, st[lcp_pkg::STAT_NACK_BIT]});
    xfer(1'b0, 1'b0, 8'hF9, 8'hC3, st);
    chk("busy device nack", 1, {31'h0, st[lcp_pkg::STAT_NACK_BIT]});
    poll(1'b0, 8'hF9, 8'hC3, st);
    get(8'hF8, 8'h3C);
    get(8'hF9, 8'hC3);
    $display("test busy done");
  endtask : t_busy
  task automatic t_protect();
    logic [31:0] st;
    poll(1'b0, lcp_pkg::CTRL_TWO_ADDR, 8'h08, st);
    poll(1'b0, 8'hF8, 8'h99, st);
    get(8'hF8, 8'h3C);
    poll(1'b0, lcp_pkg::CTRL_TWO_ADDR, 8'hFF, st);
    get(lcp_pkg::CTRL_TWO_ADDR, 8'h7F);
    chk("reserved bit seen", 0, {31'h0, fault});
    $display("test protect done");
  endtask : t_protect
  task automatic t_sel();
    logic [31:0] st;
    xfer(1'b0, 1'b1, 8'hF8, 8'h55, st);
    chk("wrong select nack", 1, {31'h0, st[lcp_pkg::STAT_NACK_BIT]});
    ahb(lcp_pkg::REG_CTRL, 1'b0, 32'h0, st);
    chk("ctrl readback", 32'h1 << lcp_pkg::CTRL_SEL_BIT, st);
    ahb(lcp_pkg::REG_MEM, 1'b0, 32'h0, st);
    chk("mem readback", 32'h0000_00F8, st);
    ahb(lcp_pkg::REG_WDATA, 1'b0, 32'h0, st);
    chk("wdata readback", 32'h0000_0055, st);
    get(8'hF8, 8'h3C);
    $display("test select done");
  endtask : t_sel
  initial begin
    failures = 0;
    cmp_count = 0;
    mclk = 1'b0;
    reset = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_fields();
    t_busy();
    t_protect();
    t_sel();
    end_sim();
  end
endmodule : lcp_master_test
